// ==== hw/seeie_engine.sv ====
// two-wire eeprom slave: instruction engine, page latch, write fifo and array
`timescale 1ns/1ps

module seeie_fifo #(
	parameter int W     = 20,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("seeie_fifo depth must be a power of two of at least 2");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;

	assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule : seeie_fifo

module seeie_engine import seeie_pkg::*; #(
	parameter int INTERNAL_WRITE_TIME_US = 1000,
	parameter int FIFO_DEPTH             = SEEIE_FIFO_DEPTH,
	parameter int DRAIN_DIV              = SEEIE_DRAIN_DIV
) (
	input  wire logic SYS_CLK,
	input  wire logic RSTN,
	input  wire logic SCL_IN,
	input  wire logic SDA_IN,
	output logic      SDA_OUT,
	output logic      SDA_OE,
	input  wire logic WRITE_PROTECT_INPUT,
	input  wire logic CHIP_SELECT_BIT2,
	input  wire logic CHIP_SELECT_BIT1,
	input  wire logic CHIP_SELECT_BIT0,
	output logic      WRITE_BUSY
);
	localparam int WRITE_CYCLES = (INTERNAL_WRITE_TIME_US * SEEIE_NS_PER_US) / SEEIE_CLK_PERIOD_NS;
	localparam int TW           = $clog2(WRITE_CYCLES + 1);
	localparam int DW           = $clog2(DRAIN_DIV + 1);
	localparam int FW           = SEEIE_ADDR_W + 8;

	if (WRITE_CYCLES < 1 || DRAIN_DIV < 1 || FIFO_DEPTH < 2) begin : g_chk
		$error("seeie_engine parameters out of range");
	end

	// pin synchroniser: stage one feeds stage two only
	logic [SEEIE_PINS-1:0] pin_meta_q;
	logic [SEEIE_PINS-1:0] pin_q;
	logic                  scl_prev_q;
	logic                  sda_prev_q;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pin_meta_q <= '1;
			pin_q      <= '1;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0,
				WRITE_PROTECT_INPUT, SDA_IN, SCL_IN};
			pin_q      <= pin_meta_q;
			scl_prev_q <= pin_q[SEEIE_PIN_SCL];
			sda_prev_q <= pin_q[SEEIE_PIN_SDA];
		end
	end

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl      = pin_q[SEEIE_PIN_SCL];
	assign sda      = pin_q[SEEIE_PIN_SDA];
	assign scl_rise = scl && !scl_prev_q;
	assign scl_fall = !scl && scl_prev_q;
	assign start_ev = scl && scl_prev_q && sda_prev_q && !sda;
	assign stop_ev  = scl && scl_prev_q && !sda_prev_q && sda;

	// array, all ones as delivered; a declaration value keeps the write process the only writer
	logic [7:0] array_mem [2**SEEIE_ADDR_W] = '{default: SEEIE_ERASED};

	seeie_state_t              state_q;
	logic [3:0]                bit_q;
	logic                      in_ack_q;
	logic                      read_q;
	logic                      master_ack_q;
	logic                      armed_q;
	logic [7:0]                sh_q;
	logic [7:0]                tx_q;
	logic [7:0]                hi_q;
	logic [SEEIE_ADDR_W-1:0]   addr_q;
	logic [7:0]                page_q [SEEIE_PAGE_BYTES];
	logic [SEEIE_PAGE_BYTES-1:0] valid_q;
	logic [SEEIE_ADDR_W-SEEIE_PAGE_W-1:0] page_base_q;
	logic                      busy_q;
	logic                      drive_q;

	function automatic logic select_match(input logic [7:0] b, input logic [2:0] cs);
		return b[SEEIE_SEL_ID_HI:SEEIE_SEL_ID_LO] == SEEIE_TYPE_ID
			&& b[SEEIE_SEL_CS_HI:SEEIE_SEL_CS_LO] == cs;
	endfunction : select_match

	logic       wp;
	logic [2:0] cs;
	logic       write_go;
	assign wp       = pin_q[SEEIE_PIN_WP];
	assign cs       = pin_q[SEEIE_PIN_CS_HI:SEEIE_PIN_CS_LO];
	// stop in the slot after a data ack with something latched
	assign write_go = stop_ev && armed_q && (|valid_q) && !busy_q;

	// bit level framing; busy blocks every bus event
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q      <= SEEIE_ST_STANDBY;
			bit_q        <= '0;
			in_ack_q     <= 1'b0;
			read_q       <= 1'b0;
			master_ack_q <= 1'b0;
			armed_q      <= 1'b0;
			sh_q         <= '0;
			tx_q         <= '0;
			hi_q         <= '0;
			drive_q      <= 1'b0;
		end else if (busy_q) begin
			state_q  <= SEEIE_ST_STANDBY;
			drive_q  <= 1'b0;
			armed_q  <= 1'b0;
			in_ack_q <= 1'b0;
			bit_q    <= '0;
		end else if (start_ev) begin
			state_q  <= SEEIE_ST_SELECT;
			bit_q    <= '0;
			in_ack_q <= 1'b0;
			armed_q  <= 1'b0;
			drive_q  <= 1'b0;
		end else if (stop_ev) begin
			state_q <= SEEIE_ST_STANDBY;
			armed_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (state_q != SEEIE_ST_STANDBY) begin
			if (scl_rise) begin
				if (bit_q < SEEIE_LAST_BIT) begin
					sh_q  <= {sh_q[6:0], sda};
					bit_q <= bit_q + 1'b1;
				end else if (in_ack_q && state_q == SEEIE_ST_RDATA) begin
					master_ack_q <= !sda;
				end
			end else if (scl_fall) begin
				// a stop needs the clock high, so the arm must outlive the tenth slot's rising edge
				armed_q <= 1'b0;
				if (in_ack_q) begin
					// end of the ninth slot
					in_ack_q <= 1'b0;
					bit_q    <= '0;
					drive_q  <= 1'b0;
					unique case (state_q)
						SEEIE_ST_SELECT: begin
							if (read_q) begin
								state_q <= SEEIE_ST_RDATA;
								tx_q    <= array_mem[addr_q];
								drive_q <= !array_mem[addr_q][7];
							end else begin
								state_q <= SEEIE_ST_ADDR_HI;
							end
						end
						SEEIE_ST_ADDR_HI: state_q <= SEEIE_ST_ADDR_LO;
						SEEIE_ST_ADDR_LO: state_q <= SEEIE_ST_WDATA;
						SEEIE_ST_WDATA:   armed_q <= 1'b1;
						SEEIE_ST_RDATA: begin
							if (master_ack_q) begin
								tx_q    <= array_mem[addr_q];
								drive_q <= !array_mem[addr_q][7];
							end else begin
								state_q <= SEEIE_ST_STANDBY;
							end
						end
						default: state_q <= SEEIE_ST_STANDBY;
					endcase
				end else if (bit_q == SEEIE_LAST_BIT) begin
					// byte complete: decide the ninth slot
					in_ack_q <= 1'b1;
					drive_q  <= 1'b0;
					unique case (state_q)
						SEEIE_ST_SELECT: begin
							if (select_match(sh_q, cs)) begin
								drive_q <= 1'b1;
								read_q  <= sh_q[SEEIE_SEL_RW];
							end else begin
								state_q <= SEEIE_ST_STANDBY;
							end
						end
						SEEIE_ST_ADDR_HI: begin
							hi_q    <= sh_q;
							drive_q <= 1'b1;
						end
						SEEIE_ST_ADDR_LO: drive_q <= 1'b1;
						SEEIE_ST_WDATA:   drive_q <= !wp;
						SEEIE_ST_RDATA:   master_ack_q <= 1'b0;
						default:          state_q <= SEEIE_ST_STANDBY;
					endcase
				end else if (state_q == SEEIE_ST_RDATA && bit_q >= SEEIE_FIRST_BIT) begin
					tx_q    <= {tx_q[6:0], 1'b0};
					drive_q <= !tx_q[6];
				end
			end
		end
	end

	// address counter and page latch
	logic                    latch_wr;
	logic [SEEIE_PAGE_W-1:0] byte_idx;
	assign latch_wr = !busy_q && !start_ev && !stop_ev && scl_fall && !in_ack_q
		&& bit_q == SEEIE_LAST_BIT && state_q == SEEIE_ST_WDATA && !wp;
	assign byte_idx = addr_q[SEEIE_PAGE_W-1:0];

	logic                      clear_valid;
	logic [SEEIE_PAGE_W:0]     scan_q;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_q      <= '0;
			valid_q     <= '0;
			page_base_q <= '0;
		end else begin
			if (clear_valid) begin
				valid_q <= '0;
			end
			if (!busy_q && !start_ev && !stop_ev && scl_fall) begin
				if (!in_ack_q && bit_q == SEEIE_LAST_BIT && state_q == SEEIE_ST_ADDR_LO) begin
					addr_q  <= {hi_q[SEEIE_ADDR_W-9:0], sh_q};
					valid_q <= '0;
				end else if (latch_wr) begin
					valid_q[byte_idx] <= 1'b1;
					page_base_q       <= addr_q[SEEIE_ADDR_W-1:SEEIE_PAGE_W];
					// in-page increment leaves bits 11 to 5 untouched
					addr_q[SEEIE_PAGE_W-1:0] <= byte_idx + 1'b1;
				end else if (!in_ack_q && bit_q == SEEIE_LAST_BIT && state_q == SEEIE_ST_RDATA) begin
					addr_q <= addr_q + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (latch_wr) begin
			page_q[byte_idx] <= sh_q;
		end
	end

	// write cycle: timer, page scan into the fifo, paced drain into the array
	logic [TW-1:0] timer_q;
	logic [DW-1:0] div_q;
	logic          drain_en;
	logic          push_valid;
	logic          push_ready;
	logic [FW-1:0] push_data;
	logic          pop_valid;
	logic [FW-1:0] pop_data;
	logic          scan_done;

	assign scan_done  = scan_q == SEEIE_PAGE_BYTES[SEEIE_PAGE_W:0];
	assign push_valid = busy_q && !scan_done && valid_q[scan_q[SEEIE_PAGE_W-1:0]];
	assign push_data  = {page_base_q, scan_q[SEEIE_PAGE_W-1:0], page_q[scan_q[SEEIE_PAGE_W-1:0]]};
	assign drain_en   = div_q == '0;
	assign clear_valid = busy_q && scan_done && timer_q == '0 && !pop_valid;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_q  <= 1'b0;
			timer_q <= '0;
			scan_q  <= '0;
		end else if (write_go) begin
			busy_q  <= 1'b1;
			timer_q <= TW'(WRITE_CYCLES);
			scan_q  <= '0;
		end else if (busy_q) begin
			if (timer_q != '0) begin
				timer_q <= timer_q - 1'b1;
			end
			// a full fifo stalls the scan
			if (!scan_done && (!push_valid || push_ready)) begin
				scan_q <= scan_q + 1'b1;
			end
			if (clear_valid) begin
				busy_q <= 1'b0;
			end
		end
	end

	// drain is paced so a long page really backs up the fifo
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_q <= '0;
		end else if (drain_en) begin
			div_q <= DW'(DRAIN_DIV - 1);
		end else begin
			div_q <= div_q - 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (pop_valid && drain_en) begin
			array_mem[pop_data[FW-1:8]] <= pop_data[7:0];
		end
	end

	seeie_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rstn      (RSTN),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (pop_valid),
		.out_ready (drain_en),
		.out_data  (pop_data)
	);

	// open-drain: only ever pulls low
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SDA_OUT    <= 1'b0;
			SDA_OE     <= 1'b0;
			WRITE_BUSY <= 1'b0;
		end else begin
			SDA_OUT    <= 1'b0;
			SDA_OE     <= drive_q && !busy_q;
			WRITE_BUSY <= busy_q;
		end
	end
endmodule : seeie_engine

// ==== hw/seeie_pkg.sv ====
// shared constants of the serial eeprom instruction engine
package seeie_pkg;
	// device type identifier of the select byte; value is arbitrary
	localparam logic [3:0]  SEEIE_TYPE_ID      = 4'h5;
	localparam int          SEEIE_ADDR_W       = 12;
	localparam int          SEEIE_PAGE_W       = 5;
	localparam int          SEEIE_PAGE_BYTES   = 32;
	localparam logic [7:0]  SEEIE_ERASED       = 8'hFF;
	localparam logic [3:0]  SEEIE_LAST_BIT     = 4'h8;
	localparam logic [3:0]  SEEIE_FIRST_BIT    = 4'h1;
	localparam int          SEEIE_CLK_PERIOD_NS = 10;
	localparam int          SEEIE_NS_PER_US    = 1000;
	localparam int          SEEIE_FIFO_DEPTH   = 16;
	localparam int          SEEIE_DRAIN_DIV    = 4;
	// select byte fields
	localparam int          SEEIE_SEL_ID_HI    = 7;
	localparam int          SEEIE_SEL_ID_LO    = 4;
	localparam int          SEEIE_SEL_CS_HI    = 3;
	localparam int          SEEIE_SEL_CS_LO    = 1;
	localparam int          SEEIE_SEL_RW       = 0;
	// synchronised pin vector layout
	localparam int          SEEIE_PIN_SCL      = 0;
	localparam int          SEEIE_PIN_SDA      = 1;
	localparam int          SEEIE_PIN_WP       = 2;
	localparam int          SEEIE_PIN_CS_LO    = 3;
	localparam int          SEEIE_PIN_CS_HI    = 5;
	localparam int          SEEIE_PINS         = 6;

	typedef enum logic [2:0] {
		SEEIE_ST_STANDBY,
		SEEIE_ST_SELECT,
		SEEIE_ST_ADDR_HI,
		SEEIE_ST_ADDR_LO,
		SEEIE_ST_WDATA,
		SEEIE_ST_RDATA
	} seeie_state_t;
endpackage : seeie_pkg

// ==== sim/seeie_engine_bench.sv ====
// self-checking bench of the eeprom instruction engine
`timescale 1ns/1ps
module seeie_engine_bench import seeie_pkg::*;;
	logic        sys_clk, rstn, scl, drv_low, oe, sda_out, wp, busy, ack;
	logic [2:0]  cs;
	logic [7:0]  d;
	logic [11:0] a, nxt;
	logic [7:0]  mem [4096];
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	wire         sda = (oe ? sda_out : 1'b1) & ~drv_low;

	seeie_engine #(.INTERNAL_WRITE_TIME_US(1)) seeie_engine_i (.SYS_CLK(sys_clk), .RSTN(rstn), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(oe), .WRITE_PROTECT_INPUT(wp), .CHIP_SELECT_BIT2(cs[2]),
		.CHIP_SELECT_BIT1(cs[1]), .CHIP_SELECT_BIT0(cs[0]), .WRITE_BUSY(busy));
	seeie_master seeie_master_i (.scl(scl), .sda_drv_low(drv_low), .sda(sda));

	function automatic logic [11:0] in_page(input logic [11:0] b, input int k);
		return {b[11:5], 5'(int'(b[4:0]) + k)};
	endfunction : in_page
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic sel(input logic rw);
		seeie_master_i.start();
		seeie_master_i.put({SEEIE_TYPE_ID, cs, rw}, ack);
	endtask : sel
	task automatic point(input logic [11:0] b);
		sel(1'b0);
		check(12'(ack), 12'h1);
		seeie_master_i.put({4'($urandom), b[11:8]}, ack);
		check(12'(ack), 12'h1);
		seeie_master_i.put(b[7:0], ack);
		check(12'(ack), 12'h1);
	endtask : point
	task automatic finish_write(input logic exp_busy);
		int n;
		seeie_master_i.stop();
		repeat (4) @(posedge sys_clk);
		#1;
		check(12'(busy), 12'(exp_busy));
		n = 0;
		do begin
			sel(1'b0);
			if (n == 0) check(12'(ack), 12'(!exp_busy));
			seeie_master_i.stop();
			n++;
		end while (!ack && n < 20);
		check(12'(ack), 12'h1);
		check(12'(busy), 12'h0);
	endtask : finish_write
	task automatic write_page(input logic [11:0] b, input int n);
		point(b);
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			seeie_master_i.put(d, ack);
			check(12'(ack), 12'(!wp));
			if (!wp) mem[in_page(b, k)] = d;
		end
		nxt = wp ? b : in_page(b, n);
		finish_write(!wp);
	endtask : write_page
	task automatic read_seq(input logic [11:0] b, input int n);
		sel(1'b1);
		check(12'(ack), 12'h1);
		for (int k = 0; k < n; k++) begin
			seeie_master_i.get(k < n - 1, d);
			check({4'h0, d}, {4'h0, mem[12'(b + k)]});
		end
		seeie_master_i.stop();
		check(12'(oe), 12'h0);
		nxt = 12'(b + n);
	endtask : read_seq

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// bus traffic below needs well under 40000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'hFD61));
		rstn = 1'b0;
		wp = 1'b0;
		cs = 3'($urandom);
		foreach (mem[i]) mem[i] = SEEIE_ERASED;
		repeat (4) @(posedge sys_clk);
		#1 rstn = 1'b1;
		repeat (6) @(posedge sys_clk);
		point(12'hFFE);
		read_seq(12'hFFE, 4);
		$display("erased read with wrap done");
		for (int i = 0; i < 2; i++) begin
			seeie_master_i.start();
			seeie_master_i.put(i ? {SEEIE_TYPE_ID, ~cs, 1'b1} : {~SEEIE_TYPE_ID, cs, 1'b1}, ack);
			check(12'(ack), 12'h0);
			seeie_master_i.stop();
		end
		$display("foreign select done");
		a = {7'($urandom), 5'h1E};
		write_page(a, 34);
		read_seq(nxt, 2);
		point(in_page(a, 0));
		read_seq(in_page(a, 0), 32);
		$display("page roll-over done");
		@(posedge sys_clk);
		#1 wp = 1'b1;
		a = 12'($urandom);
		write_page(a, 3);
		point(a);
		read_seq(a, 3);
		@(posedge sys_clk);
		#1 wp = 1'b0;
		$display("protected write done");
		for (int i = 0; i < 4; i++) begin
			a = 12'($urandom);
			write_page(a, i ? 1 + $urandom_range(31) : 1);
			read_seq(nxt, 1);
			point(a);
			read_seq(a, 2);
		end
		$display("random writes done");
		tally_and_finish();
	end
endmodule : seeie_engine_bench

bind seeie_engine seeie_engine_sva #(.INTERNAL_WRITE_TIME_US(INTERNAL_WRITE_TIME_US)) seeie_engine_sva_i (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.WRITE_PROTECT_INPUT(WRITE_PROTECT_INPUT), .CHIP_SELECT_BIT2(CHIP_SELECT_BIT2),
	.CHIP_SELECT_BIT1(CHIP_SELECT_BIT1), .CHIP_SELECT_BIT0(CHIP_SELECT_BIT0), .WRITE_BUSY(WRITE_BUSY));

// ==== sim/seeie_engine_sva.sv ====
// port assertions of the eeprom instruction engine
`timescale 1ns/1ps
module seeie_engine_sva import seeie_pkg::*; #(
	parameter int INTERNAL_WRITE_TIME_US = 1000
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic WRITE_PROTECT_INPUT,
	input wire logic CHIP_SELECT_BIT2,
	input wire logic CHIP_SELECT_BIT1,
	input wire logic CHIP_SELECT_BIT0,
	input wire logic WRITE_BUSY
);
	localparam int MIN_CYC = INTERNAL_WRITE_TIME_US * SEEIE_NS_PER_US / SEEIE_CLK_PERIOD_NS;
	// slack covers the fifo drain of a full page
	localparam int MAX_CYC = MIN_CYC + 400;
	int busy_cnt_q;
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_cnt_q <= 0;
		end else begin
			busy_cnt_q <= WRITE_BUSY ? busy_cnt_q + 1 : 0;
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	busy_quiet_a: assert property (WRITE_BUSY |-> !SDA_OE)
		else $error("data line pulled during write cycle");
	busy_min_a: assert property ($fell(WRITE_BUSY) |-> busy_cnt_q >= MIN_CYC - 1)
		else $error("write cycle too short");
	busy_max_a: assert property (WRITE_BUSY |-> busy_cnt_q < MAX_CYC)
		else $error("write cycle never ends");
	busy_on_stop_a: assert property ($rose(WRITE_BUSY) |-> SCL_IN && SDA_IN)
		else $error("write cycle began outside a stop");
	busy_no_wp_a: assert property ($rose(WRITE_BUSY) |-> !WRITE_PROTECT_INPUT)
		else $error("write cycle began while protected");
	drive_in_low_a: assert property ($rose(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2))
		else $error("data line taken while clock high");
	oe_stands_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
		else $error("data line changed while clock high");
	drive_low_a: assert property (SDA_OE |-> SDA_OUT == 1'b0)
		else $error("driven data line not low");
endmodule : seeie_engine_sva

// ==== sim/seeie_master.sv ====
// two-wire bus master model; clock stands high between frames
`timescale 1ns/1ps
module seeie_master (
	output logic      scl,
	output logic      sda_drv_low,
	input  wire logic sda
);
	localparam realtime HALF = 62.5;
	initial begin
		scl = 1'b1;
		sda_drv_low = 1'b0;
	end
	// release first and wait a full phase so a slave ack cannot turn into a stop
	task automatic start();
		sda_drv_low = 1'b0;
		#(HALF) scl = 1'b1;
		#(HALF) sda_drv_low = 1'b1;
		#(HALF) scl = 1'b0;
	endtask : start
	task automatic stop();
		#15 sda_drv_low = 1'b1;
		#(HALF - 15) scl = 1'b1;
		#(HALF) sda_drv_low = 1'b0;
		#(HALF);
	endtask : stop
	task automatic clk_bit(input logic b, output logic r);
		#15 sda_drv_low = ~b;
		#(HALF - 15) scl = 1'b1;
		#(HALF) r = sda;
		scl = 1'b0;
	endtask : clk_bit
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = ~r;
	endtask : put
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(~ack, r);
	endtask : get
endmodule : seeie_master
